/* design/sfp_port.sv */
// serial flash spi slave port: shifter, select, hold, protect gate
// assumes link pins are asynchronous and sampled by clk_sys (100 MHz)
// Notes on behaviour
// - output bit changes only after a falling serial clock edge or a select falling edge
// - input bit sampled on every rising serial clock edge while selected and not held
// - select high means unselected and serial_out released
// - deselected goes to standby only after internal cycle ends
// - select low makes the port active and ready for a command
// - commands ignored until a select falling edge after power-up
// - during hold: output released, inputs ignored, state kept
// - write protect low freezes the three protect size bits
// - both clock modes: sample rising, drive falling
// - only the selected device drives the shared output
// - hold starts and ends only while serial clock is low
// - deselect during hold resets interface; restart needs release
// - modify commands rejected unless clock count is multiple of 8; here frame_whole flags every whole frame and modify_cmd has no effect
`timescale 1ns/1ns
`include "sfp_params.svh"
module sfp_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic serial_in,
    input wire logic pause_n,
    input wire logic wprot_n,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_first,
    input wire logic modify_cmd,
    output logic frame_end,
    output logic frame_whole,
    input wire logic busy,
    input wire logic [2:0] prot_wr_data,
    input wire logic prot_wr,
    output logic [2:0] protect_size,
    output logic active,
    output logic standby,
    output logic held,
    output logic armed
);
    typedef struct packed {
        logic [1:0] sc, sl, si, ps, wp;
        sfp_pkg::sfp_state_type st;
        logic armed;
        logic [`SFP_BITCNT_W-1:0] bits;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic first;
        logic pend_first;
        logic outb;
        logic [2:0] prot;
        logic fend;
        logic fwhole;
        logic [7:0] rxb;
        logic rxv;
    } sfp_state_type;
    sfp_state_type s_q, s_d;
    logic sc_rise, sc_fall, sel_fall, sel_rise, fifo_in_ready;

    // edges from the second sync stage and its registered copy only
    logic sc_prev_q, sl_prev_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sc_prev_q <= 1'b0;
            // low like the sync stages: a select held low since
            // power-up must not look like a falling edge
            sl_prev_q <= 1'b0;
        end else begin
            sc_prev_q <= s_q.sc[1];
            sl_prev_q <= s_q.sl[1];
        end
    end
    assign sc_rise = s_q.sc[1] && !sc_prev_q;
    assign sc_fall = !s_q.sc[1] && sc_prev_q;
    assign sel_fall = !s_q.sl[1] && sl_prev_q;
    assign sel_rise = s_q.sl[1] && !sl_prev_q;

    // main sequencing
    always_comb begin
        s_d = s_q;
        s_d.sc = {s_q.sc[0], sclk};
        s_d.sl = {s_q.sl[0], sel_n};
        s_d.si = {s_q.si[0], serial_in};
        s_d.ps = {s_q.ps[0], pause_n};
        s_d.wp = {s_q.wp[0], wprot_n};
        s_d.fend = 1'b0;
        s_d.fwhole = 1'b0;
        // byte handed to fifo leaves when taken
        if (s_q.rxv && fifo_in_ready) begin
            s_d.rxv = 1'b0;
        end
        if (sel_fall) begin
            s_d.armed = 1'b1;
        end
        case (s_q.st)
            sfp_pkg::SFP_IDLE: begin
                if (sel_fall) begin
                    s_d.st = sfp_pkg::SFP_RUN;
                    s_d.bits = '0;
                    s_d.pend_first = 1'b1;
                    s_d.sh_out = 8'hff;
                    s_d.outb = 1'b1; // mode 0 first bit has no fall
                end
            end
            sfp_pkg::SFP_WAIT: begin
                // deselected in hold: wait for pause release
                if (s_q.ps[1] && sel_fall) begin
                    s_d.st = sfp_pkg::SFP_RUN;
                    s_d.bits = '0;
                    s_d.pend_first = 1'b1;
                    s_d.sh_out = 8'hff;
                    s_d.outb = 1'b1;
                end
            end
            sfp_pkg::SFP_RUN: begin
                if (sel_rise) begin
                    s_d.st = sfp_pkg::SFP_IDLE;
                    s_d.fend = 1'b1;
                    s_d.fwhole = (s_q.bits == '0);
                end else if (!s_q.ps[1] && !s_q.sc[1]) begin
                    s_d.st = sfp_pkg::SFP_HOLD;
                end else begin
                    if (sc_rise) begin
                        // msb first capture
                        s_d.sh_in = {s_q.sh_in[6:0], s_q.si[1]};
                        s_d.bits = s_q.bits + `SFP_BITCNT_W'(1);
                        if (s_q.bits == 3'h7 && s_q.armed) begin
                            s_d.rxb = {s_q.sh_in[6:0], s_q.si[1]};
                            s_d.rxv = 1'b1;
                            s_d.first = s_q.pend_first;
                            s_d.pend_first = 1'b0;
                        end
                    end
                    if (sc_fall) begin
                        // shift out after falling edge
                        if (s_q.bits == '0 && !s_q.pend_first) begin
                            s_d.outb = (tx_valid ? tx_data[7] : 1'b1);
                            s_d.sh_out = {(tx_valid ? tx_data[6:0]
                                                    : 7'h7f), 1'b1};
                        end else begin
                            s_d.outb = s_q.sh_out[7];
                            s_d.sh_out = {s_q.sh_out[6:0], 1'b1};
                        end
                    end
                end
            end
            sfp_pkg::SFP_HOLD: begin
                if (sel_rise) begin
                    s_d.st = sfp_pkg::SFP_WAIT;
                    s_d.bits = '0;
                end else if (s_q.ps[1] && !s_q.sc[1]) begin
                    s_d.st = sfp_pkg::SFP_RUN;
                end
            end
            default: s_d.st = sfp_pkg::SFP_IDLE;
        endcase
        // protect bits frozen while protect pin low
        if (prot_wr && s_q.wp[1]) begin
            s_d.prot = prot_wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.sl <= 2'b00;
            s_q.ps <= 2'b11;
            s_q.wp <= 2'b11;
            s_q.sh_out <= 8'hff;
            s_q.outb <= 1'b1;
            s_q.st <= sfp_pkg::SFP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // tx byte consumed when it is loaded into the shifter
    assign tx_ready = (s_q.st == sfp_pkg::SFP_RUN) && sc_fall
        && s_q.bits == '0 && !s_q.pend_first;

    sfp_fifo #(
        .WIDTH(9),
        .DEPTH(`SFP_FIFO_DEPTH),
        .AW(`SFP_FIFO_AW)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(1'b0),
        .in_data({s_q.first, s_q.rxb}),
        .in_valid(s_q.rxv),
        .in_ready(fifo_in_ready),
        .out_data({rx_first, rx_data}),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // output released unless in run state and selected
    assign serial_out_oe = (s_q.st == sfp_pkg::SFP_RUN) && !s_q.sl[1];
    assign serial_out = s_q.outb;
    assign frame_end = s_q.fend;
    assign frame_whole = s_q.fwhole && modify_cmd || s_q.fwhole;
    assign protect_size = s_q.prot;
    assign active = !s_q.sl[1] || busy;
    assign standby = s_q.sl[1] && !busy;
    assign held = (s_q.st == sfp_pkg::SFP_HOLD);
    assign armed = s_q.armed;

    // checks
    property p_oe_off_when_desel;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.sl[1] |-> !serial_out_oe;
    endproperty
    a_oe_off_when_desel: assert property (p_oe_off_when_desel)
        else $error("output driven while deselected");
    property p_out_change_on_fall;
        @(posedge clk_sys) disable iff (!rst_n)
        !sc_fall && !sel_fall |=> $stable(serial_out);
    endproperty
    a_out_change_on_fall: assert property (p_out_change_on_fall)
        else $error("output changed without falling clock");
    property p_no_rx_unarmed;
        @(posedge clk_sys) disable iff (!rst_n)
        !s_q.armed |=> !$rose(s_q.rxv);
    endproperty
    a_no_rx_unarmed: assert property (p_no_rx_unarmed)
        else $error("byte taken before first select fall");
    property p_hold_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        held |-> !serial_out_oe ##1 ($stable(s_q.bits) || !held);
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("hold disturbed state or drove output");
    property p_prot_frozen;
        @(posedge clk_sys) disable iff (!rst_n)
        !s_q.wp[1] |=> $stable(protect_size);
    endproperty
    a_prot_frozen: assert property (p_prot_frozen)
        else $error("protect bits changed while frozen");
    property p_hold_entry_clk_low;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(held) |-> !$past(s_q.sc[1]);
    endproperty
    a_hold_entry_clk_low: assert property (p_hold_entry_clk_low)
        else $error("hold entered with clock high");
    property p_whole_frame;
        @(posedge clk_sys) disable iff (!rst_n)
        frame_whole |-> frame_end ##0 $past(s_q.bits) == '0;
    endproperty
    a_whole_frame: assert property (p_whole_frame)
        else $error("partial frame flagged whole");
    property p_capture_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        sc_rise && s_q.st == sfp_pkg::SFP_RUN && !sel_rise
            && s_q.ps[1] |=> s_q.sh_in[0] == $past(s_q.si[1]);
    endproperty
    a_capture_rise: assert property (p_capture_rise)
        else $error("input bit not captured on rising edge");
    c_byte: cover property (@(posedge clk_sys) $rose(s_q.rxv));
    c_hold: cover property (@(posedge clk_sys) $rose(held));
    c_wait: cover property (@(posedge clk_sys)
        s_q.st == sfp_pkg::SFP_WAIT);
endmodule

/* design/sfp_params.svh */
// constants of the serial flash slave port
// assumes inclusion by bare name from design files only
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_FIFO_DEPTH 8
`define SFP_FIFO_AW 3
`define SFP_BYTE_W 8
`define SFP_BITCNT_W 3
`define SFP_STATUS_RST 8'h00
`define SFP_PROT_LSB 2
`define SFP_PROT_W 3
`endif

/* design/sfp_pkg.sv */
// types of the serial flash slave port
// assumes sfp_params.svh sits beside it
package sfp_pkg;
    typedef enum logic [1:0] {
        SFP_IDLE = 2'b00,
        SFP_WAIT = 2'b01,
        SFP_RUN = 2'b10,
        SFP_HOLD = 2'b11
    } sfp_state_type;
endpackage

/* design/sfp_fifo.sv */
// small flop fifo with valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
module sfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sfp_fifo_state_type;
    sfp_fifo_state_type s_q, s_d;
    logic push, pop;

    // handshakes are combinational, data comes from flops
    assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + AW'(1);
        end
        if (pop) begin
            s_d.rp = s_q.rp + AW'(1);
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - (AW+1)'(1);
        end
        if (clr) begin
            s_d.wp = '0;
            s_d.rp = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* tb/sfp_master.sv */
// spi bus master model: select, clock, data and pause pins
// assumes the bench calls its tasks from one process, clk_sys 100 MHz
`timescale 1ns/1ns
module sfp_master (
    input wire logic clk_sys,
    output logic sclk,
    output logic sel_n,
    output logic serial_in,
    output logic pause_n,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic cpol = 1'b0;
    logic miso;
    // a released line shows the inverse, never a stale bit
    assign miso = serial_out_oe ? serial_out : ~serial_out;
    // select low since power-up, pause driven firm
    initial begin
        sclk = 1'b0;
        sel_n = 1'b0;
        serial_in = 1'b0;
        pause_n = 1'b1;
    end
    // half of a 160 ns link clock period
    task automatic half();
        repeat (8) @(negedge clk_sys);
    endtask
    // clock parked first, so select never rises with it
    task automatic select(input logic lo);
        sclk = cpol;
        half();
        sel_n = ~lo;
        half();
    endtask
    // msb first, drive while low, sample at rise
    task automatic bits(input logic [7:0] d, input int n,
        output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            serial_in = d[7-i];
            half();
            r[7-i] = miso;
            sclk = 1'b1;
            half();
        end
        if (!cpol) sclk = 1'b0;
    endtask
    // pause moves only with clock low; select is left where the caller put it
    task automatic pause(input logic on);
        sclk = 1'b0;
        half();
        pause_n = ~on;
        half();
    endtask
    // junk activity that a held port must ignore; even n ends low
    task automatic junk(input int n);
        repeat (n) begin
            serial_in = 1'($urandom);
            sclk = ~sclk;
            half();
        end
    endtask
endmodule

/* tb/sfp_port_tb.sv */
// self-checking bench for the serial flash slave port
// assumes sfp_master as bus partner and a 100 MHz clk_sys
`timescale 1ns/1ns
module sfp_port_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, sel_n, serial_in, pause_n, serial_out, serial_out_oe;
    logic wprot_n = 1'b1;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0, tx_ready;
    logic [7:0] rx_data, r, b;
    logic rx_valid, rx_ready = 1'b0, rx_first, frame_end, frame_whole;
    logic busy = 1'b0, prot_wr = 1'b0, active, standby, held, armed;
    logic [2:0] prot_wr_data = 3'h0, protect_size, prot_exp = 3'h0;
    logic drain = 1'b1, watch = 1'b0, modify_cmd = 1'b0;
    logic [8:0] rx_q[$];
    logic fr_q[$];
    int fail_count = 0, n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    sfp_port sfp_port_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sclk(sclk),
        .sel_n(sel_n),
        .serial_in(serial_in),
        .pause_n(pause_n),
        .wprot_n(wprot_n),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .rx_first(rx_first),
        .modify_cmd(modify_cmd),
        .frame_end(frame_end),
        .frame_whole(frame_whole),
        .busy(busy),
        .prot_wr_data(prot_wr_data),
        .prot_wr(prot_wr),
        .protect_size(protect_size),
        .active(active),
        .standby(standby),
        .held(held),
        .armed(armed)
    );
    sfp_master sfp_master_inst (
        .clk_sys(clk_sys),
        .sclk(sclk),
        .sel_n(sel_n),
        .serial_in(serial_in),
        .pause_n(pause_n),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watcher: random pops of the fifo head, frame ends against notes
    // ready chosen first: the head seen now is what the next edge pops
    always @(negedge clk_sys) begin
        rx_ready = drain & 1'($urandom);
        if (rx_ready && rx_valid)
            check({rx_first, rx_data}, rx_q.size() ? rx_q.pop_front() : 'x);
        if (frame_end && watch)
            check(frame_whole, fr_q.size() ? fr_q.pop_front() : 'x);
    end
    // one whole frame: command byte then n data bytes both ways
    task automatic frame(input int n);
        logic [7:0] c;
        c = 8'($urandom);
        tx_data = 8'($urandom);
        tx_valid = 1'($urandom);
        modify_cmd = 1'($urandom);
        sfp_master_inst.select(1'b1);
        check(active, 1'b1);
        // notes go in before the bytes: the port answers mid-call
        rx_q.push_back({1'b1, c});
        sfp_master_inst.bits(c, 8, r);
        check(r, 8'hff);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            rx_q.push_back({1'b0, b});
            sfp_master_inst.bits(b, 8, r);
            check(r, tx_valid ? tx_data : 8'hff);
        end
        fr_q.push_back(1'b1);
        sfp_master_inst.select(1'b0);
        check(serial_out_oe, 1'b0);
    endtask
    // hang guard: about 90k cycles
    initial begin
        #900000;
        fail_count++;
        end_sim();
    end
    initial begin
        b = 8'($urandom(96));
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        // select low since power-up: no falling edge, byte dropped
        sfp_master_inst.bits(8'h5a, 8, r);
        repeat (8) @(negedge clk_sys);
        check(rx_valid, 1'b0);
        check(armed, 1'b0);
        sfp_master_inst.select(1'b0);
        watch = 1'b1;
        // mode 0 short and long, then mode 3
        frame(0);
        frame(3);
        sfp_master_inst.cpol = 1'b1;
        frame(2);
        sfp_master_inst.cpol = 1'b0;
        // twelve clocks: byte kept, frame count not whole
        sfp_master_inst.select(1'b1);
        rx_q.push_back({1'b1, 8'hc3});
        sfp_master_inst.bits(8'hc3, 8, r);
        sfp_master_inst.bits(8'ha0, 4, r);
        fr_q.push_back(1'b0);
        sfp_master_inst.select(1'b0);
        // hold in mid-byte: junk ignored, byte survives the pause
        b = 8'($urandom);
        sfp_master_inst.select(1'b1);
        sfp_master_inst.bits(b, 4, r);
        sfp_master_inst.pause(1'b1);
        check(held, 1'b1);
        check(serial_out_oe, 1'b0);
        sfp_master_inst.junk(6);
        check(active, 1'b1);
        sfp_master_inst.pause(1'b0);
        check(held, 1'b0);
        rx_q.push_back({1'b1, b});
        sfp_master_inst.bits(b << 4, 4, r);
        fr_q.push_back(1'b1);
        sfp_master_inst.select(1'b0);
        // deselect while held: restart needs release, then select
        sfp_master_inst.select(1'b1);
        rx_q.push_back({1'b1, 8'h3c});
        sfp_master_inst.bits(8'h3c, 8, r);
        sfp_master_inst.pause(1'b1);
        watch = 1'b0;
        sfp_master_inst.select(1'b0);
        watch = 1'b1;
        sfp_master_inst.pause(1'b0);
        frame(1);
        // all eight fifo slots filled with no pops, then drained
        drain = 1'b0;
        frame(7);
        drain = 1'b1;
        // protect size frozen while wprot_n is low
        for (int i = 0; i < 4; i++) begin
            wprot_n = i[0];
            prot_wr_data = 3'($urandom);
            if (i[0]) prot_exp = prot_wr_data;
            repeat (4) @(negedge clk_sys);
            prot_wr = 1'b1;
            @(negedge clk_sys);
            prot_wr = 1'b0;
            repeat (5) @(negedge clk_sys);
            check(protect_size, prot_exp);
        end
        // standby only once the internal cycle has ended
        busy = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(standby, 1'b0);
        busy = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(standby, 1'b1);
        for (int i = 0; i < 2000 && rx_q.size() > 0; i++)
            @(negedge clk_sys);
        check(9'(rx_q.size() + fr_q.size()), 9'h000);
        end_sim();
    end
endmodule
